// [rtl/tsi_core.sv]
// Purpose: captured-time registers, switch-over capture and shared interrupt pin
// Assumes: strobes in tsi_event_t are single-cycle on clock; pulse_64hz marks 64 Hz edges
// Notes: captured bytes hold no reset; the interrupt pin is open-drain, low when enabled
//
// Summary of operation
// - 12-hour hour: pm bit5, tens bit4, units
// - 24-hour hour: tens bits 5-4, units 3-0
// - hour layout chosen by hour format bit
// - day byte BCD 1-31, bits 7-6 zero
// - month byte BCD 1-12, bits 7-5 zero
// - year byte BCD 0-99, all bits
// - unimplemented captured bits read as zero
// - captured bits undefined at power-on, reset-proof
// - capture disabled: switch-over leaves captures alone
// - enabled, flag clear: capture and set flag on one edge
// - enabled, flag set: ignore switch-over and tamper
// - one open-drain low interrupt, seven sources
// - all sources disabled: pin stays released
// - pulse select: tick/countdown pulse or level
// - other sources follow their own flag
// - host clears tick, countdown, alarm, capture, switch-over
// - watchdog flag cannot be cleared by host
// - low-battery flag clears itself on replacement
// - second enable wins; minute alone per minute
// - tick flag set on enabled counter increment
// - pulse mode pulses; level holds until cleared
// - tick pulse ends at the next 64 Hz mark
// - capture interrupt follows capture flags, level only
// - tamper event captures time and sets flags on one edge
`timescale 1ns/1ps
`default_nettype none
module tsi_core
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // host control and commands
  input wire tsi_pkg::tsi_ctrl_t ctrl,
  input wire tsi_pkg::tsi_clear_t clear,
  input wire logic [7:0] rd_addr,
  // time and event sources
  input wire tsi_pkg::tsi_time_t now,
  input wire tsi_pkg::tsi_event_t event_in,
  input wire logic watchdog_flag,
  // asynchronous levels from the power monitor
  input wire logic switchover_async,
  input wire logic low_battery_async,
  // host read-back
  output logic [7:0] rd_data,
  output tsi_pkg::tsi_flags_t flags,
  // open-drain interrupt pin
  output logic int_out,
  output logic int_oe
);
  import tsi_pkg::*;

  // converts 24-hour BCD into the selected captured layout
  function automatic logic [5:0] hour_fmt(input logic [1:0] tens, input logic [3:0] units,
                                          input logic twelve);
    logic [4:0] h;
    logic [4:0] h12;
    logic pm;
    logic ten;
    logic [4:0] u;
    h = 5'(tens) * TSI_TEN + 5'(units);
    pm = (h >= TSI_NOON);
    h12 = pm ? h - TSI_NOON : h;
    if (h12 == 5'h00)
    begin
      h12 = TSI_NOON;
    end
    ten = (h12 >= TSI_TEN);
    u = ten ? h12 - TSI_TEN : h12;
    if (twelve)
    begin
      hour_fmt = {pm, ten, u[3:0]};
    end
    else
    begin
      hour_fmt = {tens, units};
    end
  endfunction

  // synchronisers for the power monitor levels
  logic [1:0] so_sync_reg;
  logic [1:0] so_sync_next;
  logic so_prev_reg;
  logic so_prev_next;
  logic [1:0] lb_sync_reg;
  logic [1:0] lb_sync_next;
  logic so_event;

  always_comb
  begin
    so_sync_next = {so_sync_reg[0], switchover_async};
    lb_sync_next = {lb_sync_reg[0], low_battery_async};
    so_prev_next = so_sync_reg[1];
    so_event = so_sync_reg[1] & ~so_prev_reg; // rising edge of the synced level
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      so_sync_reg <= TSI_SYNC_RESET;
      lb_sync_reg <= TSI_SYNC_RESET;
      so_prev_reg <= 1'b0;
    end
    else
    begin
      so_sync_reg <= so_sync_next;
      lb_sync_reg <= lb_sync_next;
      so_prev_reg <= so_prev_next;
    end
  end

  // capture decisions and flag next values
  logic locked;
  logic tamper_any;
  logic take_tamper;
  logic take_switch;
  logic capture;
  logic tick_set;
  tsi_flags_t flags_reg;
  tsi_flags_t flags_next;

  always_comb
  begin
    locked = ctrl.backup_capture_enable & flags_reg.battery_switchover_flag;
    tamper_any = event_in.tamper_mid | event_in.tamper_ground;
    take_tamper = tamper_any & ~locked;
    take_switch = so_event & ctrl.backup_capture_enable & ~locked;
    capture = take_tamper | take_switch;
    // second enable dominates, minute alone gives one per minute
    if (ctrl.second_tick_enable)
    begin
      tick_set = event_in.second_inc;
    end
    else
    begin
      tick_set = ctrl.sixty_second_tick_enable & event_in.minute_inc;
    end
    // set wins over a clear in the same cycle
    flags_next = flags_reg;
    flags_next.tick_flag = tick_set | (flags_reg.tick_flag & ~clear.tick_flag);
    flags_next.countdown_flag = event_in.countdown_done
      | (flags_reg.countdown_flag & ~clear.countdown_flag);
    flags_next.alarm_flag = event_in.alarm_match
      | (flags_reg.alarm_flag & ~clear.alarm_flag);
    flags_next.capture_flag_one = take_tamper
      | (flags_reg.capture_flag_one & ~clear.capture_flag_one);
    flags_next.capture_flag_two = (take_tamper & event_in.tamper_ground)
      | (flags_reg.capture_flag_two & ~clear.capture_flag_two);
    flags_next.battery_switchover_flag = (so_event & ~locked)
      | (flags_reg.battery_switchover_flag & ~clear.battery_switchover_flag);
    // watchdog and low-battery flags only mirror their sources; no host clear
    flags_next.watchdog_flag = watchdog_flag;
    flags_next.low_battery_flag = lb_sync_reg[1];
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags_reg <= '0;
    end
    else
    begin
      flags_reg <= flags_next;
    end
  end

  // captured-time bytes: no reset, so later resets leave them as they were
  logic [5:0] cap_hour_reg;
  logic [5:0] cap_hour_next;
  logic [5:0] cap_day_reg;
  logic [5:0] cap_day_next;
  logic [4:0] cap_month_reg;
  logic [4:0] cap_month_next;
  logic [7:0] cap_year_reg;
  logic [7:0] cap_year_next;

  always_comb
  begin
    cap_hour_next = cap_hour_reg;
    cap_day_next = cap_day_reg;
    cap_month_next = cap_month_reg;
    cap_year_next = cap_year_reg;
    if (capture)
    begin
      cap_hour_next = hour_fmt(now.hour_tens, now.hour_units, ctrl.twelve_hour_mode);
      cap_day_next = now.day;
      cap_month_next = now.month;
      cap_year_next = now.year;
    end
  end

  always_ff @(posedge clock)
  begin
    cap_hour_reg <= cap_hour_next;
    cap_day_reg <= cap_day_next;
    cap_month_reg <= cap_month_next;
    cap_year_reg <= cap_year_next;
  end

  // 64 Hz pulse stretchers for tick and countdown, shortened by a clear
  logic [1:0] pulse_reg;
  logic [1:0] pulse_next;
  logic [1:0] pulse_start;
  logic [1:0] pulse_kill;

  always_comb
  begin
    pulse_start = {event_in.countdown_done, tick_set};
    pulse_kill = {clear.countdown_flag, clear.tick_flag};
    for (int i = 0; i < 2; i++)
    begin
      if (pulse_start[i])
      begin
        pulse_next[i] = 1'b1;
      end
      else if (event_in.pulse_64hz | pulse_kill[i])
      begin
        pulse_next[i] = 1'b0;
      end
      else
      begin
        pulse_next[i] = pulse_reg[i];
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pulse_reg <= 2'h0;
    end
    else
    begin
      pulse_reg <= pulse_next;
    end
  end

  // interrupt request combining and read-back mux
  logic tick_en;
  logic tick_req;
  logic cd_req;
  logic irq_any;
  logic int_oe_reg;
  logic int_oe_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;

  always_comb
  begin
    // a tick flag left set must not hold the pin once both tick enables are off
    tick_en = ctrl.second_tick_enable | ctrl.sixty_second_tick_enable;
    tick_req = tick_en & (ctrl.pulse_mode_select ? pulse_reg[0] : flags_reg.tick_flag);
    cd_req = ctrl.pulse_mode_select ? pulse_reg[1] : flags_reg.countdown_flag;
    irq_any = tick_req
      | (ctrl.countdown_irq_enable & cd_req)
      | (ctrl.watchdog_irq_enable & flags_reg.watchdog_flag)
      | (ctrl.alarm_irq_enable & flags_reg.alarm_flag)
      | (ctrl.capture_irq_enable
         & (flags_reg.capture_flag_one | flags_reg.capture_flag_two))
      | (ctrl.switchover_irq_enable & flags_reg.battery_switchover_flag)
      | (ctrl.low_battery_irq_enable & flags_reg.low_battery_flag);
    // the pin only pulls low while an enabled source requests; otherwise released
    int_oe_next = irq_any;
    unique case (rd_addr)
      TSI_OFS_HOUR: rd_data_next = {2'h0, cap_hour_reg};
      TSI_OFS_DAY: rd_data_next = {2'h0, cap_day_reg};
      TSI_OFS_MONTH: rd_data_next = {3'h0, cap_month_reg};
      TSI_OFS_YEAR: rd_data_next = cap_year_reg;
      default: rd_data_next = TSI_RD_RESET;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      int_oe_reg <= 1'b0;
      rd_data_reg <= TSI_RD_RESET;
    end
    else
    begin
      int_oe_reg <= int_oe_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // outputs straight from flip-flops, except int_out tied to 0; the pin only ever pulls low
  assign int_oe = int_oe_reg;
  assign int_out = 1'b0;
  assign rd_data = rd_data_reg;
  assign flags = flags_reg;
endmodule
`default_nettype wire

// [rtl/tsi_pkg.sv]
// Purpose: shared constants and carrier types for the capture and interrupt block
// Assumes: one 125 MHz clock; time and tick strobes arrive on that clock
// Notes: captured-time registers have no reset value by design
`default_nettype none
package tsi_pkg;
  // register offsets of the captured-time bytes
  localparam logic [7:0] TSI_OFS_HOUR = 8'h15;
  localparam logic [7:0] TSI_OFS_DAY = 8'h16;
  localparam logic [7:0] TSI_OFS_MONTH = 8'h17;
  localparam logic [7:0] TSI_OFS_YEAR = 8'h18;
  // field positions of the captured hour
  localparam int TSI_HOUR_PM_BIT = 5;
  localparam int TSI_HOUR_TENS12_BIT = 4;
  // values after reset
  localparam logic [7:0] TSI_RD_RESET = 8'h00;
  localparam logic [1:0] TSI_SYNC_RESET = 2'h0;
  // hour conversion constants
  localparam logic [4:0] TSI_NOON = 5'h0C;
  localparam logic [4:0] TSI_TEN = 5'h0A;

  // present time in 24-hour BCD from the time counters
  typedef struct packed {
    logic [1:0] hour_tens;
    logic [3:0] hour_units;
    logic [5:0] day;
    logic [4:0] month;
    logic [7:0] year;
  } tsi_time_t;

  // control bits written by the host
  typedef struct packed {
    logic twelve_hour_mode;
    logic backup_capture_enable;
    logic pulse_mode_select;
    logic second_tick_enable;
    logic sixty_second_tick_enable;
    logic countdown_irq_enable;
    logic watchdog_irq_enable;
    logic alarm_irq_enable;
    logic capture_irq_enable;
    logic switchover_irq_enable;
    logic low_battery_irq_enable;
  } tsi_ctrl_t;

  // one-cycle event strobes from neighbouring engines
  typedef struct packed {
    logic pulse_64hz;
    logic second_inc;
    logic minute_inc;
    logic countdown_done;
    logic alarm_match;
    logic tamper_mid;
    logic tamper_ground;
  } tsi_event_t;

  // one-cycle host clear commands
  typedef struct packed {
    logic tick_flag;
    logic countdown_flag;
    logic alarm_flag;
    logic capture_flag_one;
    logic capture_flag_two;
    logic battery_switchover_flag;
  } tsi_clear_t;

  // flag state visible to the host
  typedef struct packed {
    logic tick_flag;
    logic countdown_flag;
    logic alarm_flag;
    logic capture_flag_one;
    logic capture_flag_two;
    logic battery_switchover_flag;
    logic watchdog_flag;
    logic low_battery_flag;
  } tsi_flags_t;
endpackage
`default_nettype wire

// [verif/tsi_host_model.sv]
// Purpose: host view of the shared open-drain interrupt line
// Assumes: the board pulls the line up when nobody drives it
// Notes: the host only ever sees the resolved level
`timescale 1ns/1ps
`default_nettype none
module tsi_host_model
(
  // pin as driven by the block
  input wire logic int_out,
  input wire logic int_oe,
  // level seen by the host
  output logic int_pin_n
);
  // a released line floats up to the pull-up level
  assign int_pin_n = int_oe ? int_out : 1'b1;
endmodule
`default_nettype wire

// [verif/tsi_core_asserts.sv]
// Purpose: port-level checks of the capture and interrupt block
// Assumes: flags and int_oe are registered one edge after their cause
// Notes: bound into every tsi_core instance
`timescale 1ns/1ps
`default_nettype none
module tsi_core_asserts
(
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // watched inputs
  input wire tsi_pkg::tsi_ctrl_t ctrl,
  input wire logic [7:0] rd_addr,
  input wire tsi_pkg::tsi_event_t event_in,
  input wire logic watchdog_flag,
  // watched outputs
  input wire logic [7:0] rd_data,
  input wire tsi_pkg::tsi_flags_t flags,
  input wire logic int_out,
  input wire logic int_oe
);
  import tsi_pkg::*;
  logic none_en;
  logic lvl_req;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // the eight source enables sit in the low byte of the control word
  assign none_en = (ctrl[7:0] == 8'h00);
  // enabled level sources that hold their flag
  assign lvl_req = (ctrl.switchover_irq_enable && flags.battery_switchover_flag)
    || (ctrl.capture_irq_enable && (flags.capture_flag_one || flags.capture_flag_two))
    || (ctrl.low_battery_irq_enable && flags.low_battery_flag);
  // steps of the capture behaviour
  sequence s_locked;
    ctrl.backup_capture_enable && flags.battery_switchover_flag;
  endsequence
  sequence s_ground;
    event_in.tamper_ground && !(ctrl.backup_capture_enable && flags.battery_switchover_flag);
  endsequence
  a_pin_low: assert property (int_out == 1'b0)
    else $error("pin value not low");
  a_idle_released: assert property (none_en [*3] |-> !int_oe)
    else $error("pin driven with all sources off");
  a_level_follow: assert property (lvl_req |=> int_oe)
    else $error("level source not on pin");
  a_ground_flags: assert property (s_ground |=> flags.capture_flag_one && flags.capture_flag_two)
    else $error("capture flags not set");
  a_locked_ignore: assert property (s_locked ##0 (event_in.tamper_ground
    && !flags.capture_flag_two) |=> !flags.capture_flag_two)
    else $error("event taken while locked");
  a_watchdog_copy: assert property ($past(arst_n) |-> flags.watchdog_flag == $past(watchdog_flag))
    else $error("watchdog flag not following");
  a_second_tick: assert property (ctrl.second_tick_enable && event_in.second_inc
    |=> flags.tick_flag)
    else $error("second tick missed");
  a_tick_level: assert property (!ctrl.pulse_mode_select && flags.tick_flag
    && ctrl.sixty_second_tick_enable |=> int_oe)
    else $error("tick level not on pin");
  a_unused_zero: assert property (rd_addr == TSI_OFS_MONTH |=> rd_data[7:5] == 3'h0)
    else $error("month unused bits set");
  a_unmapped_zero: assert property (rd_addr > TSI_OFS_YEAR |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind tsi_core tsi_core_asserts tsi_core_asserts_inst (.clock(clock), .arst_n(arst_n),
  .ctrl(ctrl), .rd_addr(rd_addr), .event_in(event_in), .watchdog_flag(watchdog_flag),
  .rd_data(rd_data), .flags(flags), .int_out(int_out), .int_oe(int_oe));
`default_nettype wire

// [verif/tb_timestamp_capture_and_irq_output.sv]
// Purpose: self-checking bench for tsi_core
// Assumes: inputs move on the falling edge of clock
// Notes: the pin is judged through the host model
`timescale 1ns/1ps
`default_nettype none
module tb_timestamp_capture_and_irq_output;
  import tsi_pkg::*;
  logic clock, arst_n, watchdog_flag, switchover_async, low_battery_async;
  logic int_out, int_oe, int_pin_n;
  logic [7:0] rd_addr, rd_data;
  tsi_ctrl_t ctrl;
  tsi_clear_t clear;
  tsi_time_t now;
  tsi_event_t event_in;
  tsi_flags_t flags;
  int miscompares, cmp_count;
  // block and the host view of its pin
  tsi_core tsi_core_inst (.clock(clock), .arst_n(arst_n), .ctrl(ctrl), .clear(clear),
    .rd_addr(rd_addr), .now(now), .event_in(event_in), .watchdog_flag(watchdog_flag),
    .switchover_async(switchover_async), .low_battery_async(low_battery_async),
    .rd_data(rd_data), .flags(flags), .int_out(int_out), .int_oe(int_oe));
  tsi_host_model tsi_host_model_inst (.int_out(int_out), .int_oe(int_oe),
    .int_pin_n(int_pin_n));
  // 125 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // byte compare
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clock);
  endtask
  // read data stands one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_addr = a;
    step(1);
    chk(rd_data, exp);
  endtask
  // one-cycle strobes and clears, then time for flag and pin
  task automatic pul(input tsi_event_t e, input tsi_clear_t c);
    event_in = e;
    clear = c;
    step(1);
    event_in = '0;
    clear = '0;
    step(2);
  endtask
  task automatic fp(input logic [7:0] f, input logic pin);
    chk(flags, f);
    chk({7'h00, int_pin_n}, {7'h00, pin});
  endtask
  // ground tamper capture in 24-hour layout, mid tamper capture in 12-hour layout
  task automatic t_capture;
    ctrl = 11'h004;
    now = {2'h2, 4'h3, 6'h31, 5'h12, 8'h99};
    pul(7'h01, 6'h00);
    fp(8'h18, 1'b0);
    rd(TSI_OFS_HOUR, 8'h23);
    rd(TSI_OFS_DAY, 8'h31);
    rd(TSI_OFS_MONTH, 8'h12);
    rd(TSI_OFS_YEAR, 8'h99);
    rd(8'h19, 8'h00);
    ctrl = 11'h404;
    pul(7'h02, 6'h00);
    rd(TSI_OFS_HOUR, 8'h31);
    pul(7'h00, 6'h06);
    fp(8'h00, 1'b1);
    $display("capture done");
  endtask
  // minute-only level tick, then pulsed second tick
  task automatic t_tick;
    ctrl = 11'h040;
    pul(7'h20, 6'h00);
    fp(8'h00, 1'b1);
    pul(7'h10, 6'h00);
    fp(8'h80, 1'b0);
    pul(7'h40, 6'h00);
    fp(8'h80, 1'b0);
    ctrl = 11'h000;
    step(2);
    fp(8'h80, 1'b1);
    pul(7'h00, 6'h20);
    fp(8'h00, 1'b1);
    ctrl = 11'h1C0;
    pul(7'h20, 6'h00);
    fp(8'h80, 1'b0);
    pul(7'h40, 6'h00);
    fp(8'h80, 1'b1);
    pul(7'h00, 6'h20);
    ctrl = 11'h120;
    pul(7'h08, 6'h00);
    fp(8'h40, 1'b0);
    pul(7'h00, 6'h10);
    fp(8'h00, 1'b1);
    $display("tick done");
  endtask
  // countdown, alarm, watchdog and low battery
  task automatic t_others;
    ctrl = 11'h028;
    pul(7'h08, 6'h00);
    fp(8'h40, 1'b0);
    pul(7'h04, 6'h10);
    fp(8'h20, 1'b0);
    pul(7'h00, 6'h08);
    fp(8'h00, 1'b1);
    ctrl = 11'h011;
    watchdog_flag = 1'b1;
    low_battery_async = 1'b1;
    step(5);
    pul(7'h00, 6'h3F);
    fp(8'h03, 1'b0);
    watchdog_flag = 1'b0;
    low_battery_async = 1'b0;
    step(6);
    fp(8'h00, 1'b1);
    $display("others done");
  endtask
  // switch-over with capture off, on and locked, then a reset
  task automatic t_switch;
    ctrl = 11'h002;
    now = {2'h0, 4'h7, 6'h01, 5'h01, 8'h00};
    switchover_async = 1'b1;
    step(7);
    fp(8'h04, 1'b0);
    rd(TSI_OFS_YEAR, 8'h99);
    switchover_async = 1'b0;
    pul(7'h00, 6'h01);
    ctrl = 11'h200;
    switchover_async = 1'b1;
    step(7);
    rd(TSI_OFS_HOUR, 8'h07);
    fp(8'h04, 1'b1);
    now = {2'h1, 4'h2, 6'h02, 5'h02, 8'h01};
    pul(7'h01, 6'h00);
    rd(TSI_OFS_DAY, 8'h01);
    chk(flags, 8'h04);
    arst_n = 1'b0;
    step(1);
    chk(flags, 8'h00);
    arst_n = 1'b1;
    rd(TSI_OFS_HOUR, 8'h07);
    $display("switch-over done");
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset for 8 cycles, then the scenarios
  initial
  begin
    arst_n = 1'b0;
    {ctrl, clear, event_in} = '0;
    {watchdog_flag, switchover_async, low_battery_async} = 3'h0;
    rd_addr = 8'h00;
    now = '0;
    miscompares = 0;
    cmp_count = 0;
    step(8);
    arst_n = 1'b1;
    step(1);
    fp(8'h00, 1'b1);
    t_capture();
    t_tick();
    t_others();
    t_switch();
    report_and_stop();
  end
  // hang guard, far beyond the roughly 100 cycles the run needs
  initial
  begin
    #40000;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire
